// >>> sleep_pkg.sv
// Constants for the pin-controlled power-down hold block
// How it works
// R1: Sleep pin acts only when configured so
// R2: Power-down lasts while enabled pin is high
// R3: Outputs and internal state latched and held
// R4: Tristated outputs stay tristated throughout power-down
// R5: All inputs except sleep pin ignored
// R6: Pin hold latches keep last level
// R7: Enable is static configuration, not runtime
// R8: Sleep pin level never feeds logic array
// R9: Sleep pin macrocell stays usable otherwise
// R10: Outputs valid within 1 us after release
// R11: Two sleep pins, each also general I/O
// R12: Resume from held state after recovery
package sleep_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int RECOVERY_US = 1;
   localparam int RECOVERY_CYCLES = (RECOVERY_US * 1000) / CLK_PERIOD_NS;
   localparam int PIN_COUNT = 8;
   localparam int SLEEP_PIN_COUNT = 2;
   localparam int CNT_W = 8;
   typedef enum logic [1:0] {
      ST_RUN,
      ST_SLEEP,
      ST_RECOVER
   } pd_state_t;
endpackage : sleep_pkg

// >>> pin_hold_latch.sv
// Per-pin hold register: tracks live level or keeps last level
`timescale 1ns/1ps
`default_nettype none
module pin_hold_latch #(
   parameter int W = 8
) (
   input wire logic clk, // Clock
   input wire logic reset_n, // Async reset, active low
   input wire logic hold, // Keep last level
   input wire logic [W-1:0] d, // Live level
   output logic [W-1:0] q // Held or tracked level
);
   // Track while running, freeze while holding
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else if (!hold) begin
         q <= d;
      end
   end
endmodule : pin_hold_latch
`default_nettype wire

// >>> pin_power_down_hold.sv
// Power-down sequencer with output and pin hold for a small logic device
`timescale 1ns/1ps
`default_nettype none
module pin_power_down_hold
   import sleep_pkg::*;
#(
   parameter int W = sleep_pkg::PIN_COUNT,
   parameter int RECOVERY = sleep_pkg::RECOVERY_CYCLES
) (
   input wire logic clk, // 100 MHz clock
   input wire logic reset_n, // Async reset, active low
   input wire logic [sleep_pkg::SLEEP_PIN_COUNT-1:0] sleep_cfg_en, // Static power-down enables
   input wire logic [sleep_pkg::SLEEP_PIN_COUNT-1:0] sleep_pin_i, // Sleep pin levels
   output logic [sleep_pkg::SLEEP_PIN_COUNT-1:0] sleep_pin_o, // Sleep pin I/O drive
   output logic [sleep_pkg::SLEEP_PIN_COUNT-1:0] sleep_pin_oe, // Sleep pin I/O enable
   input wire logic [sleep_pkg::SLEEP_PIN_COUNT-1:0] sleep_fn_o, // Logic drive for sleep pins
   input wire logic [sleep_pkg::SLEEP_PIN_COUNT-1:0] sleep_fn_oe, // Logic enable for sleep pins
   output logic [sleep_pkg::SLEEP_PIN_COUNT-1:0] sleep_fn_i, // Sleep pin level to logic
   input wire logic [W-1:0] pin_i, // General I/O pin levels
   output logic [W-1:0] pin_o, // General I/O drive
   output logic [W-1:0] pin_oe, // General I/O enable
   input wire logic [W-1:0] core_o, // Logic array output data
   input wire logic [W-1:0] core_oe, // Logic array output enables
   output logic [W-1:0] core_i, // Pin levels presented to logic
   output logic core_run, // Logic may advance its state
   output logic powered_down, // Power-down active
   output logic outputs_valid // Recovery complete
);
   pd_state_t state_ff;
   pd_state_t nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic sleep_req;
   logic [W-1:0] held_pins;
   logic [SLEEP_PIN_COUNT-1:0] held_sleep_pins;
   logic recover_done;
   logic hold_now;

   // Running test shared by hold, output and status logic
   function automatic logic is_run(input pd_state_t st);
      return (st == ST_RUN);
   endfunction : is_run

   // Asleep test shared by status logic
   function automatic logic is_sleep(input pd_state_t st);
      return (st == ST_SLEEP);
   endfunction : is_sleep

   // Last recovery cycle; counter restarts if sleep comes back
   assign recover_done = (cnt_ff == CNT_W'(RECOVERY - 1)); // R10

   // Latches hold from the entry edge on, not one cycle later
   assign hold_now = !is_run(nxt_state); // R6

   // Only configured pins may request sleep; either pin suffices
   assign sleep_req = |(sleep_cfg_en & sleep_pin_i); // R1 R2 R7 R11

   // Power-down sequencing
   // Sleep during recovery wins, so a short wake never half-resumes
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_RUN: begin
            if (sleep_req) begin
               nxt_state = ST_SLEEP; // R2
            end
         end
         ST_SLEEP: begin
            if (!sleep_req) begin
               nxt_state = ST_RECOVER; // R2
            end
         end
         ST_RECOVER: begin
            if (sleep_req) begin
               nxt_state = ST_SLEEP;
            end else if (recover_done) begin
               nxt_state = ST_RUN; // R10 R12
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Recovery timer; no reset of held state on wake
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= '0;
      end else if (state_ff == ST_RECOVER && nxt_state == ST_RECOVER) begin
         cnt_ff <= cnt_ff + CNT_W'(1); // R10
      end else begin
         cnt_ff <= '0;
      end
   end

   // Hold pin levels while not running so pins never float
   pin_hold_latch #(.W(W)) u_pin_hold (
      .clk(clk),
      .reset_n(reset_n),
      .hold(hold_now), // R6
      .d(pin_i),
      .q(held_pins)
   );

   // Sleep pins also general I/O; config-enabled ones never reach logic
   pin_hold_latch #(.W(SLEEP_PIN_COUNT)) u_sleep_hold (
      .clk(clk),
      .reset_n(reset_n),
      .hold(hold_now), // R6 R11
      .d(sleep_pin_i & ~sleep_cfg_en), // R8
      .q(held_sleep_pins)
   );

   // Inputs to logic: frozen copy, so changes during sleep have no effect
   // Costs two cycles of input latency from pin_i, but no glitch reaches the logic
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         core_i <= '0;
      end else begin
         core_i <= held_pins; // R5 R12
      end
   end

   // Sleep pin level to logic; enabled pins always read low
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sleep_fn_i <= '0;
      end else begin
         sleep_fn_i <= held_sleep_pins; // R5 R8
      end
   end

   // General pin data freezes at its last running value
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_o <= '0;
      end else if (is_run(nxt_state)) begin
         pin_o <= core_o; // R3
      end
   end

   // Enables freeze too, so a pin in high-Z stays in high-Z
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_oe <= '0;
      end else if (is_run(nxt_state)) begin
         pin_oe <= core_oe; // R4
      end
   end

   // Macrocell drive still available when the pin is not a sleep control
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sleep_pin_o <= '0;
      end else if (is_run(nxt_state)) begin
         sleep_pin_o <= sleep_fn_o; // R9
      end
   end

   // Enabled sleep pins never drive; the others act as general I/O
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sleep_pin_oe <= '0;
      end else if (is_run(nxt_state)) begin
         sleep_pin_oe <= sleep_fn_oe & ~sleep_cfg_en; // R9 R11
      end
   end

   // Run gating; logic must freeze its registers when low
   // No reset on wake: held state simply carries on
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         core_run <= 1'b1;
      end else begin
         core_run <= is_run(nxt_state); // R3 R12
      end
   end

   // Power-down flag covers the sleep state only, not recovery
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         powered_down <= 1'b0;
      end else begin
         powered_down <= is_sleep(nxt_state); // R2
      end
   end

   // Valid stays low through the whole recovery wait
   // so the controller never trusts outputs early
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         outputs_valid <= 1'b1;
      end else begin
         outputs_valid <= is_run(nxt_state); // R10
      end
   end
endmodule : pin_power_down_hold
`default_nettype wire

// >>> pd_hold_monitor.sv
// Checker for the power-down hold block
`timescale 1ns/1ps
`default_nettype none
module pd_hold_monitor #(parameter int W = 8, parameter int RECOVERY = 4) (
   input wire logic clk, // Clock
   input wire logic reset_n, // Reset
   input wire logic [1:0] sleep_cfg_en, // Enables
   input wire logic [1:0] sleep_pin_i, // Sleep levels
   input wire logic [1:0] sleep_pin_oe, // Pin enable
   input wire logic [1:0] sleep_fn_i, // To logic
   input wire logic [W-1:0] core_o, // Logic data
   input wire logic [W-1:0] pin_o, // Drive
   input wire logic [W-1:0] pin_oe, // Enable
   input wire logic [W-1:0] core_i, // To logic
   input wire logic core_run, // Running
   input wire logic powered_down, // Asleep
   input wire logic outputs_valid // Valid
);
   // Request as the design takes it
   wire logic req = |(sleep_cfg_en & sleep_pin_i);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_sleep_entry: assert property (req |=> powered_down && !core_run) else $error("entry");
   chk_cfg_gate: assert property (!req |=> !powered_down) else $error("gate");
   chk_pd_invalid: assert property (powered_down |-> !outputs_valid) else $error("valid");
   chk_drive_hold: assert property (powered_down |=> $stable(pin_o) && $stable(pin_oe))
      else $error("drive hold");
   chk_input_block: assert property (powered_down |=> $stable(core_i)) else $error("inputs");
   chk_pin_reserved: assert property (!(|(sleep_cfg_en & (sleep_pin_oe | sleep_fn_i))))
      else $error("reserved");
   chk_recover_len: assert property ($rose(core_run) |->
      $past(powered_down, RECOVERY + 1) && !$past(powered_down, RECOVERY)) else $error("rec");
   chk_resume_load: assert property (core_run && !req |=> pin_o == $past(core_o))
      else $error("load");
endmodule : pd_hold_monitor
`default_nettype wire

// >>> sleep_ctrl.sv
// System controller model driving the sleep pins
`timescale 1ns/1ps
`default_nettype none
module sleep_ctrl (
   input wire logic clk, // Clock
   input wire logic [1:0] req, // Wanted levels
   output logic [1:0] pin // Pin levels
);
   // Moves only off the sampling edge, a cycle late
   initial pin = 2'h0;
   always @(negedge clk) pin <= req;
endmodule : sleep_ctrl
`default_nettype wire

// >>> pin_power_down_hold_tb_top.sv
// Bench for the power-down hold block
`timescale 1ns/1ps
`default_nettype none
module pin_power_down_hold_tb_top;
   localparam int R = 4;
   logic clk = 0, reset_n = 0, run, pd, ov;
   logic [1:0] req = 0, spi, spo, spoe, fno = 0, fnoe = 0, fni;
   logic [7:0] pi = 0, po, poe, co = 0, coe = 0, ci, ep, eo, ei, eh;
   int errors = 0, cmp_count = 0, m = 0, c = 0, n = 0;
   int unsigned s = 86516, k;
   always #5 clk = ~clk;
   sleep_ctrl u_ctl (.clk(clk), .req(req), .pin(spi));
   // Static enable on pin 0 only; its level never used as logic input
   pin_power_down_hold #(.RECOVERY(R)) u_dut (.clk(clk), .reset_n(reset_n), .sleep_cfg_en(2'h1),
      .sleep_pin_i(spi), .sleep_pin_o(spo), .sleep_pin_oe(spoe), .sleep_fn_o(fno),
      .sleep_fn_oe(fnoe), .sleep_fn_i(fni), .pin_i(pi), .pin_o(po), .pin_oe(poe), .core_o(co),
      .core_oe(coe), .core_i(ci), .core_run(run), .powered_down(pd), .outputs_valid(ov));
   function automatic int unsigned rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : rnd
   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic final_report();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   // Reference: run, sleep, recover; loads only on edges ending in run
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         m = 0; c = 0; ep = 0; eo = 0; ei = 0; eh = 0;
      end else begin
         ei = eh;
         if (spi[0]) m = 1;
         else if (m == 1) begin
            m = 2; c = 0;
         end else if (m == 2) begin
            if (c == R - 1) m = 0;
            else c = c + 1;
         end
         if (m == 0) begin
            ep = co; eo = coe; eh = pi;
         end
      end
   end
   // Compare, then drive fresh values off the sampling edge
   always @(negedge clk) if (reset_n) begin
      check("pin_o", po, ep);
      check("pin_oe", poe, eo);
      check("core_i", ci, ei);
      check("state", {pd, run, ov, fni[0]}, {m == 1, m == 0, m == 0, 1'b0});
      k = rnd();
      // Data held on the rising sleep edge, so either entry reading agrees
      if (!(req[0] && !spi[0])) begin
         co <= k[7:0]; coe <= k[15:8]; pi <= k[23:16];
      end
      fno <= k[25:24];
      fnoe <= k[27:26];
      n++;
      if (n % 16 == 0) req <= k[29:28];
   end
   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk) reset_n <= 1;
      repeat (800) @(posedge clk);
      final_report();
   end
endmodule : pin_power_down_hold_tb_top
bind pin_power_down_hold pd_hold_monitor #(.W(W), .RECOVERY(RECOVERY)) u_mon (.clk(clk),
   .reset_n(reset_n), .sleep_cfg_en(sleep_cfg_en), .sleep_pin_i(sleep_pin_i),
   .sleep_pin_oe(sleep_pin_oe), .sleep_fn_i(sleep_fn_i), .core_o(core_o), .pin_o(pin_o),
   .pin_oe(pin_oe), .core_i(core_i), .core_run(core_run), .powered_down(powered_down),
   .outputs_valid(outputs_valid));
`default_nettype wire
